// ---- rtl/dspa_top.sv ----
// Drive status word, control word decode and parameter request handling.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ns
module dspa_top (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    // Register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    // Drive conditions
    input  wire logic        ctrl_ready_i,
    input  wire logic        tripped_i,
    input  wire logic        drive_ready_i,
    input  wire logic        start_enable_i,
    input  wire logic        trip_lock_i,
    input  wire logic        error_no_trip_i,
    input  wire logic        warning_i,
    input  wire logic        speed_at_ref_i,
    input  wire logic        local_stop_i,
    input  wire logic        local_ref_i,
    input  wire logic [15:0] out_freq_i,
    input  wire logic        start_received_i,
    input  wire logic        brake_fault_i,
    input  wire logic        dc_volt_low_i,
    input  wire logic        dc_volt_high_i,
    input  wire logic [15:0] motor_current_i,
    input  wire logic [15:0] motor_thermal_i,
    input  wire logic [15:0] drive_thermal_i,
    // Control word from the network
    input  wire logic        ctrl_word_valid_i,
    input  wire logic [15:0] ctrl_word_i,
    // Drive outputs
    output logic [15:0]      drive_status_word_o,
    output logic             relay2_o,
    output logic [1:0]       setup_sel_o,
    output logic             reverse_o,
    // Parameter request input
    input  wire logic        param_req_valid_i,
    input  wire logic [7:0]  param_req_type_i,
    input  wire logic [15:0] param_req_num_i,
    input  wire logic [7:0]  param_req_sub_i,
    input  wire logic [31:0] param_req_value_i,
    output logic             param_req_ready_o,
    // Parameter response output
    output logic             param_resp_valid_o,
    output logic [7:0]       param_resp_type_o,
    output logic [15:0]      param_resp_num_o,
    output logic [7:0]       param_resp_len_o,
    output logic [31:0]      param_resp_value_o,
    // Parameter store
    output logic             store_req_o,
    output logic             store_write_o,
    output logic [15:0]      store_num_o,
    output logic [7:0]       store_sub_o,
    output logic [31:0]      store_wdata_o,
    input  wire logic        store_ack_i,
    input  wire logic        store_err_i,
    input  wire logic [7:0]  store_err_code_i,
    input  wire logic [31:0] store_rdata_i
);

    // Error value: marker in byte 0, code in byte 3.
    function automatic logic [31:0] err_value(input logic [7:0] code);
        err_value = {code, 8'h00, 8'h00, dspa_pkg::ERR_MARK};
    endfunction

    logic [31:0]        cfg_reg;
    logic [31:0]        speed_lim_reg;
    logic [31:0]        curr_lim_reg;
    logic [15:0]        ctrl_word_reg;
    logic [15:0]        status_reg;
    logic [15:0]        status_next;
    logic [15:0]        resp_count_reg;
    dspa_pkg::dspa_state_e state_reg;
    logic               native;
    logic [1:0]         dir_cfg;
    logic               err_code_ok;

    assign native  = (cfg_reg[dspa_pkg::CFG_PROFILE_BIT] == 1'b0);
    assign dir_cfg = cfg_reg[dspa_pkg::CFG_DIR_LSB +: 2];

    // Register writes.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_reg       <= dspa_pkg::CFG_RESET;
            speed_lim_reg <= dspa_pkg::SPEED_LIM_RESET;
            curr_lim_reg  <= dspa_pkg::CURR_LIM_RESET;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                dspa_pkg::ADDR_CONFIG:    cfg_reg       <= reg_wdata_i;
                dspa_pkg::ADDR_SPEED_LIM: speed_lim_reg <= reg_wdata_i;
                dspa_pkg::ADDR_CURR_LIM:  curr_lim_reg  <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // Register reads; unmapped addresses read as zero.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                dspa_pkg::ADDR_CONFIG:     reg_rdata_o <= cfg_reg;
                dspa_pkg::ADDR_SPEED_LIM:  reg_rdata_o <= speed_lim_reg;
                dspa_pkg::ADDR_CURR_LIM:   reg_rdata_o <= curr_lim_reg;
                dspa_pkg::ADDR_STATUS:     reg_rdata_o <= {16'h0000, status_reg};
                dspa_pkg::ADDR_CTRL_WORD:  reg_rdata_o <= {16'h0000, ctrl_word_reg};
                dspa_pkg::ADDR_PARAM_STAT: reg_rdata_o <= {15'h0000,
                                                           state_reg == dspa_pkg::PA_WAIT,
                                                           resp_count_reg};
                default:                   reg_rdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // Status word assembly.
    always_comb begin
        status_next = 16'h0000;
        status_next[dspa_pkg::ST_CTRL_READY]  = ctrl_ready_i & ~tripped_i;
        status_next[dspa_pkg::ST_DRIVE_READY] = drive_ready_i;
        status_next[dspa_pkg::ST_ENABLE]      = start_enable_i;
        status_next[dspa_pkg::ST_TRIP]        = tripped_i;
        status_next[dspa_pkg::ST_ERROR]       = error_no_trip_i;
        status_next[dspa_pkg::ST_TRIP_LOCK]   = trip_lock_i;
        status_next[dspa_pkg::ST_WARNING]     = warning_i;
        status_next[dspa_pkg::ST_AT_REF]      = speed_at_ref_i;
        status_next[dspa_pkg::ST_BUS_CTRL]    = ~(local_stop_i | local_ref_i);
        status_next[dspa_pkg::ST_FREQ_OK]     = (out_freq_i >= speed_lim_reg[15:0])
                                              & (out_freq_i <= speed_lim_reg[31:16]);
        status_next[dspa_pkg::ST_RUNNING]     = start_received_i
                                              | (out_freq_i != 16'h0000);
        status_next[dspa_pkg::ST_BRAKE]       = brake_fault_i;
        status_next[dspa_pkg::ST_VOLTAGE]     = dc_volt_low_i | dc_volt_high_i;
        status_next[dspa_pkg::ST_TORQUE]      = motor_current_i > curr_lim_reg[15:0];
        status_next[dspa_pkg::ST_TIMER]       = (motor_thermal_i > dspa_pkg::TIMER_FULL)
            | (drive_thermal_i > dspa_pkg::TIMER_FULL);
        if (!native) begin
            status_next = 16'h0000;
        end
    end

    // The status word is registered so the network sees a stable, glitch-free value.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_reg <= 16'h0000;
        end else begin
            status_reg <= status_next;
        end
    end

    assign drive_status_word_o = status_reg;

    // Control word decode; ignored outside the native profile.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_word_reg <= 16'h0000;
            relay2_o      <= 1'b0;
            setup_sel_o   <= 2'h0;
            reverse_o     <= 1'b0;
        end else begin
            if (ctrl_word_valid_i && native) begin
                ctrl_word_reg <= ctrl_word_i;
                if (cfg_reg[dspa_pkg::CFG_MULTI_BIT]) begin
                    setup_sel_o <= ctrl_word_i[dspa_pkg::CW_SETUP_LSB +: 2];
                end
            end
            relay2_o <= cfg_reg[dspa_pkg::CFG_RELAY_BIT]
                      & ctrl_word_reg[dspa_pkg::CW_RELAY];
            case (dir_cfg)
                dspa_pkg::DIR_FWD_ONLY: reverse_o <= 1'b0;
                dspa_pkg::DIR_REV_ONLY: reverse_o <= 1'b1;
                default: reverse_o <= ctrl_word_reg[dspa_pkg::CW_REVERSE];
            endcase
        end
    end

    // A store error code outside the known set is reported as other error.
    assign err_code_ok = (store_err_code_i >= 8'h01) && (store_err_code_i <= 8'h0b);

    // Parameter request handling: one request in flight; ready is low while waiting.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg          <= dspa_pkg::PA_IDLE;
            param_req_ready_o  <= 1'b1;
            param_resp_valid_o <= 1'b0;
            param_resp_type_o  <= 8'h00;
            param_resp_num_o   <= 16'h0000;
            param_resp_len_o   <= 8'h00;
            param_resp_value_o <= 32'h0000_0000;
            store_req_o        <= 1'b0;
            store_write_o      <= 1'b0;
            store_num_o        <= 16'h0000;
            store_sub_o        <= 8'h00;
            store_wdata_o      <= 32'h0000_0000;
            resp_count_reg     <= 16'h0000;
        end else begin
            param_resp_valid_o <= 1'b0;
            store_req_o        <= 1'b0;
            case (state_reg)
                dspa_pkg::PA_IDLE: begin
                    if (param_req_valid_i) begin
                        param_resp_num_o <= param_req_num_i;
                        if (param_req_type_i == dspa_pkg::REQ_READ
                            || param_req_type_i == dspa_pkg::REQ_WRITE) begin
                            store_req_o       <= 1'b1;
                            store_write_o     <= param_req_type_i == dspa_pkg::REQ_WRITE;
                            store_num_o       <= param_req_num_i;
                            store_sub_o       <= param_req_sub_i;
                            store_wdata_o     <= param_req_value_i;
                            param_req_ready_o <= 1'b0;
                            state_reg         <= dspa_pkg::PA_WAIT;
                        end else begin
                            param_resp_valid_o <= 1'b1;
                            param_resp_type_o  <= dspa_pkg::RESP_ERROR;
                            param_resp_len_o   <= dspa_pkg::LEN_VALUE;
                            param_resp_value_o <= err_value(dspa_pkg::ERR_BAD_TYPE);
                            resp_count_reg     <= 16'(resp_count_reg + 16'h0001);
                        end
                    end
                end
                dspa_pkg::PA_WAIT: begin
                    if (store_ack_i) begin
                        param_resp_valid_o <= 1'b1;
                        param_req_ready_o  <= 1'b1;
                        resp_count_reg     <= 16'(resp_count_reg + 16'h0001);
                        state_reg          <= dspa_pkg::PA_IDLE;
                        if (store_err_i) begin
                            param_resp_type_o  <= dspa_pkg::RESP_ERROR;
                            param_resp_len_o   <= dspa_pkg::LEN_VALUE;
                            param_resp_value_o <= err_value(err_code_ok ? store_err_code_i
                                                            : dspa_pkg::ERR_OTHER);
                        end else if (store_write_o) begin
                            param_resp_type_o  <= dspa_pkg::RESP_WRITE;
                            param_resp_len_o   <= dspa_pkg::LEN_NONE;
                            param_resp_value_o <= 32'h0000_0000;
                        end else begin
                            param_resp_type_o  <= dspa_pkg::RESP_READ;
                            param_resp_len_o   <= dspa_pkg::LEN_VALUE;
                            param_resp_value_o <= store_rdata_i;
                        end
                    end
                end
                default: begin
                    state_reg         <= dspa_pkg::PA_IDLE;
                    param_req_ready_o <= 1'b1;
                end
            endcase
        end
    end

endmodule

// ---- rtl/dspa_pkg.sv ----
// Constants shared by the drive status and parameter access block.
package dspa_pkg;
    // Register byte addresses.
    localparam logic [7:0]  ADDR_CONFIG     = 8'h00;
    localparam logic [7:0]  ADDR_SPEED_LIM  = 8'h04;
    localparam logic [7:0]  ADDR_CURR_LIM   = 8'h08;
    localparam logic [7:0]  ADDR_STATUS     = 8'h0c;
    localparam logic [7:0]  ADDR_CTRL_WORD  = 8'h10;
    localparam logic [7:0]  ADDR_PARAM_STAT = 8'h14;
    // Configuration register fields.
    localparam int          CFG_PROFILE_BIT = 0;
    localparam int          CFG_RELAY_BIT   = 1;
    localparam int          CFG_MULTI_BIT   = 2;
    localparam int          CFG_DIR_LSB     = 3;
    localparam logic [31:0] CFG_RESET       = 32'h0000_0000;
    localparam logic [31:0] SPEED_LIM_RESET = 32'hffff_0000;
    localparam logic [31:0] CURR_LIM_RESET  = 32'h0000_ffff;
    // Permitted motor direction codes.
    localparam logic [1:0]  DIR_FWD_ONLY    = 2'h0;
    localparam logic [1:0]  DIR_REV_ONLY    = 2'h1;
    localparam logic [1:0]  DIR_BOTH        = 2'h2;
    // Status word bit positions.
    localparam int          ST_CTRL_READY   = 0;
    localparam int          ST_DRIVE_READY  = 1;
    localparam int          ST_ENABLE       = 2;
    localparam int          ST_TRIP         = 3;
    localparam int          ST_ERROR        = 4;
    localparam int          ST_TRIP_LOCK    = 6;
    localparam int          ST_WARNING      = 7;
    localparam int          ST_AT_REF       = 8;
    localparam int          ST_BUS_CTRL     = 9;
    localparam int          ST_FREQ_OK      = 10;
    localparam int          ST_RUNNING      = 11;
    localparam int          ST_BRAKE        = 12;
    localparam int          ST_VOLTAGE      = 13;
    localparam int          ST_TORQUE       = 14;
    localparam int          ST_TIMER        = 15;
    // Control word bit positions.
    localparam int          CW_RELAY        = 12;
    localparam int          CW_SETUP_LSB    = 13;
    localparam int          CW_REVERSE      = 15;
    // Thermal timer value that stands for full scale.
    localparam logic [15:0] TIMER_FULL      = 16'h2710;
    // Request and response codes.
    localparam logic [7:0]  REQ_READ        = 8'h01;
    localparam logic [7:0]  REQ_WRITE       = 8'h02;
    localparam logic [7:0]  RESP_ERROR      = 8'h00;
    localparam logic [7:0]  RESP_READ       = 8'h01;
    localparam logic [7:0]  RESP_WRITE      = 8'h02;
    localparam logic [7:0]  ERR_MARK        = 8'hff;
    localparam logic [7:0]  ERR_BAD_TYPE    = 8'h01;
    localparam logic [7:0]  ERR_OTHER       = 8'hfe;
    localparam logic [7:0]  LEN_VALUE       = 8'h04;
    localparam logic [7:0]  LEN_NONE        = 8'h00;

    typedef enum logic [0:0] {
        PA_IDLE = 1'b0,
        PA_WAIT = 1'b1
    } dspa_state_e;
endpackage

// ---- sim/dspa_store_model.sv ----
// Behavioural parameter store that answers the block's store requests.
`timescale 1ns/1ns
module dspa_store_model (
    // Clock
    input  wire logic        clk_i,
    // Request from the block, and answer delay from the bench
    input  wire logic        req_i,
    input  wire logic [15:0] num_i,
    input  wire logic [3:0]  dly_i,
    // Answer to the block
    output logic             ack_o,
    output logic             err_o,
    output logic [7:0]       code_o,
    output logic [31:0]      rdata_o
);
    initial begin
        ack_o = 1'b0;
        err_o = 1'b0;
        code_o = 8'h00;
        rdata_o = 32'h0000_0000;
    end
    // Idle read data and error code lines toggle, so a sample taken outside the ack cycle is caught.
    always @(posedge clk_i) begin
        if (req_i === 1'b1) begin
            repeat (dly_i) @(posedge clk_i);
            ack_o <= 1'b1;
            err_o <= num_i[15];
            code_o <= num_i[7:0];
            rdata_o <= {~num_i, num_i};
        end else begin
            ack_o <= 1'b0;
            rdata_o <= ~rdata_o;
            code_o <= ~code_o;
        end
    end
endmodule

// ---- sim/dspa_top_assertions.sv ----
// Concurrent checks on the ports of the drive status and parameter block.
`timescale 1ns/1ns
module dspa_checker (
    // Clock and reset
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    // Drive side
    input wire logic        ctrl_ready_i,
    input wire logic        tripped_i,
    input wire logic        local_stop_i,
    input wire logic        local_ref_i,
    input wire logic [15:0] motor_thermal_i,
    input wire logic [15:0] drive_thermal_i,
    input wire logic [15:0] drive_status_word_o,
    // Parameter side
    input wire logic        param_req_valid_i,
    input wire logic [7:0]  param_req_type_i,
    input wire logic [15:0] param_req_num_i,
    input wire logic        param_req_ready_o,
    input wire logic        param_resp_valid_o,
    input wire logic [7:0]  param_resp_type_o,
    input wire logic [7:0]  param_resp_len_o,
    input wire logic [31:0] param_resp_value_o,
    input wire logic        store_req_o,
    input wire logic [15:0] store_num_o,
    input wire logic        store_write_o,
    input wire logic        store_ack_i,
    input wire logic        store_err_i,
    input wire logic [31:0] store_rdata_i
);
    logic take;
    logic good;
    assign take = param_req_valid_i && param_req_ready_o;
    assign good = param_req_type_i == dspa_pkg::REQ_READ
        || param_req_type_i == dspa_pkg::REQ_WRITE;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    AST_CTRL_READY: assert property (drive_status_word_o[0]
        |-> $past(ctrl_ready_i & ~tripped_i))
        else $error("ready bit set without its cause");
    AST_RESERVED: assert property (drive_status_word_o[5] == 1'b0)
        else $error("reserved status bit set");
    AST_BUS_CTRL: assert property (drive_status_word_o[9]
        |-> !$past(local_stop_i | local_ref_i))
        else $error("bus control bit set under local control");
    AST_THERMAL: assert property ($past(motor_thermal_i > dspa_pkg::TIMER_FULL)
        && !$past(rst_i) && drive_status_word_o != 16'h0000 |-> drive_status_word_o[15])
        else $error("thermal bit missing");
    AST_STORE_REQ: assert property (take && good |=> store_req_o && !param_req_ready_o
        && store_num_o == $past(param_req_num_i)
        && store_write_o == $past(param_req_type_i == dspa_pkg::REQ_WRITE))
        else $error("store request not issued as asked");
    AST_BAD_TYPE: assert property (take && !good |=> param_resp_valid_o ##0
        param_resp_type_o == dspa_pkg::RESP_ERROR && param_resp_value_o == 32'h0100_00ff)
        else $error("bad request type not answered with code 1");
    AST_READ_RESP: assert property (store_ack_i && !param_req_ready_o && !store_err_i
        && !store_write_o |=> param_resp_type_o == dspa_pkg::RESP_READ
        && param_resp_len_o == dspa_pkg::LEN_VALUE && param_resp_value_o == $past(store_rdata_i))
        else $error("read response fields wrong");
    AST_ACK_RESP: assert property (store_ack_i && !param_req_ready_o
        |=> param_resp_valid_o && param_req_ready_o ##1 (!param_resp_valid_o || $past(take)))
        else $error("store answer did not give one response");
    AST_ERR_SHAPE: assert property (param_resp_valid_o && param_resp_type_o == 8'h00
        |-> param_resp_value_o[7:0] == dspa_pkg::ERR_MARK && param_resp_len_o == 8'h04)
        else $error("error response without marker");
    COV_READ: cover property (store_ack_i && !store_err_i && !store_write_o);
    COV_STORE_ERR: cover property (store_ack_i && store_err_i);
    COV_BAD_TYPE: cover property (take && !good);
endmodule
bind dspa_top dspa_checker u_chk (.core_clk_i, .rst_i, .ctrl_ready_i, .tripped_i,
    .local_stop_i, .local_ref_i, .motor_thermal_i, .drive_thermal_i, .drive_status_word_o,
    .param_req_valid_i, .param_req_type_i, .param_req_num_i, .param_req_ready_o,
    .param_resp_valid_o, .param_resp_type_o, .param_resp_len_o, .param_resp_value_o,
    .store_req_o, .store_num_o, .store_write_o, .store_ack_i, .store_err_i, .store_rdata_i);

// ---- sim/tb_drive_status_and_param_access.sv ----
// Self-checking bench for the drive status and parameter block.
`timescale 1ns/1ns
`define CHECK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_drive_status_and_param_access;
    logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, cwv = 1'b0, pv = 1'b0;
    logic [7:0] addr = 8'h00, pt = 8'h00, ps = 8'h00, rt, rl, code;
    logic [31:0] wdata = 32'h0, pval = 32'h0, rdata, rval, swd, srd;
    logic [15:0] frq = 16'h0, cur = 16'h0, mth = 16'h0, dth = 16'h0, cwd = 16'h0, pn = 16'h0;
    logic [15:0] sw, rn, snum;
    logic [13:0] flg = 14'h0;
    logic [3:0] dly = 4'h0;
    logic [1:0] setup;
    logic [7:0] ssub;
    logic relay, rev, prdy, rv, sreq, swr, ack, err;
    logic [15:0] ftab [5] = '{16'h0000, 16'h0100, 16'h0200, 16'h0201, 16'h00ff};
    int num_errors = 0;
    int check_count = 0;
    always #25 clk = ~clk;
    dspa_top dut (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .ctrl_ready_i(flg[13]),
        .tripped_i(flg[12]), .drive_ready_i(flg[11]), .start_enable_i(flg[10]),
        .trip_lock_i(flg[9]), .error_no_trip_i(flg[8]), .warning_i(flg[7]),
        .speed_at_ref_i(flg[6]), .local_stop_i(flg[5]), .local_ref_i(flg[4]),
        .out_freq_i(frq), .start_received_i(flg[3]), .brake_fault_i(flg[2]),
        .dc_volt_low_i(flg[1]), .dc_volt_high_i(flg[0]), .motor_current_i(cur),
        .motor_thermal_i(mth), .drive_thermal_i(dth), .ctrl_word_valid_i(cwv),
        .ctrl_word_i(cwd), .drive_status_word_o(sw), .relay2_o(relay), .setup_sel_o(setup),
        .reverse_o(rev), .param_req_valid_i(pv), .param_req_type_i(pt), .param_req_num_i(pn),
        .param_req_sub_i(ps), .param_req_value_i(pval), .param_req_ready_o(prdy),
        .param_resp_valid_o(rv), .param_resp_type_o(rt), .param_resp_num_o(rn),
        .param_resp_len_o(rl), .param_resp_value_o(rval), .store_req_o(sreq),
        .store_write_o(swr), .store_num_o(snum), .store_sub_o(ssub), .store_wdata_o(swd),
        .store_ack_i(ack), .store_err_i(err), .store_err_code_i(code), .store_rdata_i(srd));
    dspa_store_model u_store (.clk_i(clk), .req_i(sreq), .num_i(snum), .dly_i(dly),
        .ack_o(ack), .err_o(err), .code_o(code), .rdata_o(srd));
    function automatic logic [15:0] exp_sw();
        return {mth > 16'h2710 || dth > 16'h2710, cur > 16'h0300,
            flg[1] | flg[0], flg[2], flg[3] | (frq != 16'h0),
            frq >= 16'h0100 && frq <= 16'h0200, ~(flg[5] | flg[4]), flg[6],
            flg[7], flg[9], 1'b0, flg[8], flg[12], flg[10], flg[11],
            flg[13] & ~flg[12]};
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        `CHECK("reg_rdata_o", e, rdata)
    endtask
    task automatic ctl(input logic [15:0] w, input logic [1:0] es, input logic er, input logic ev);
        @(posedge clk);
        cwd <= w;
        cwv <= 1'b1;
        @(posedge clk);
        cwv <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHECK("setup_sel_o", es, setup)
        `CHECK("relay2_o", er, relay)
        `CHECK("reverse_o", ev, rev)
    endtask
    task automatic preq(input logic [7:0] t, input logic [15:0] n, input logic [3:0] dl,
                        input logic [7:0] et, input logic [7:0] el, input logic [31:0] ev);
        int i;
        @(posedge clk);
        dly <= dl;
        pt <= t;
        pn <= n;
        ps <= n[7:0];
        pval <= {n, ~n};
        pv <= 1'b1;
        @(posedge clk);
        pv <= 1'b0;
        #1;
        for (i = 0; i < 60 && rv !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 60) begin
            num_errors++;
            complete_run();
        end
        `CHECK("param_resp_type_o", et, rt)
        `CHECK("param_resp_num_o", n, rn)
        `CHECK("param_resp_len_o", el, rl)
        `CHECK("param_resp_value_o", ev, rval)
        `CHECK("param_req_ready_o", 1'b1, prdy)
        if (t == dspa_pkg::REQ_READ || t == dspa_pkg::REQ_WRITE) begin
            `CHECK("store_num_o", n, snum)
            `CHECK("store_sub_o", n[7:0], ssub)
            `CHECK("store_wdata_o", {n, ~n}, swd)
            `CHECK("store_write_o", t == dspa_pkg::REQ_WRITE, swr)
        end
    endtask
    initial begin
        int k;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(dspa_pkg::ADDR_CONFIG, dspa_pkg::CFG_RESET);
        rd(dspa_pkg::ADDR_SPEED_LIM, dspa_pkg::SPEED_LIM_RESET);
        rd(dspa_pkg::ADDR_CURR_LIM, dspa_pkg::CURR_LIM_RESET);
        rd(8'h20, 32'h0000_0000);
        wr(dspa_pkg::ADDR_SPEED_LIM, 32'h0200_0100);
        wr(dspa_pkg::ADDR_CURR_LIM, 32'h0000_0300);
        // Each flag alone, then all but one, against frequency and limit boundaries.
        for (k = 0; k < 28; k++) begin
            @(posedge clk);
            flg <= (14'h0001 << (k % 14)) ^ ((k < 14) ? 14'h0000 : 14'h3fff);
            frq <= ftab[k % 5];
            cur <= 16'h0300 + 16'(k % 2);
            mth <= dspa_pkg::TIMER_FULL + 16'(k % 3 == 1);
            dth <= dspa_pkg::TIMER_FULL + 16'(k % 3 == 2);
            repeat (2) @(posedge clk);
            #1;
            `CHECK("drive_status_word_o", exp_sw(), sw)
        end
        rd(dspa_pkg::ADDR_STATUS, {16'h0000, exp_sw()});
        wr(dspa_pkg::ADDR_CONFIG, 32'h0000_0007);
        ctl(16'hffff, 2'h0, 1'b0, 1'b0);
        `CHECK("drive_status_word_o", 16'h0000, sw)
        wr(dspa_pkg::ADDR_CONFIG, 32'h0000_0016);
        for (k = 0; k < 4; k++) begin
            ctl({k[0], 2'(k), k[1], 12'h000}, 2'(k), k[1], k[0]);
        end
        wr(dspa_pkg::ADDR_CONFIG, 32'h0000_0000);
        ctl(16'hf000, 2'h3, 1'b0, 1'b0);
        wr(dspa_pkg::ADDR_CONFIG, 32'h0000_0008);
        ctl(16'h0000, 2'h3, 1'b0, 1'b1);
        rd(dspa_pkg::ADDR_CTRL_WORD, 32'h0000_0000);
        preq(dspa_pkg::REQ_READ, 16'h0123, 4'h0, 8'h01, 8'h04, 32'hfedc_0123);
        preq(dspa_pkg::REQ_WRITE, 16'h0456, 4'h5, 8'h02, 8'h00, 32'h0);
        preq(8'h00, 16'h0789, 4'h0, 8'h00, 8'h04, 32'h0100_00ff);
        preq(8'h03, 16'h0abc, 4'h0, 8'h00, 8'h04, 32'h0100_00ff);
        for (k = 0; k < 13; k++) begin
            preq(dspa_pkg::REQ_READ, 16'h8000 | 16'(k), 4'(k % 4), 8'h00, 8'h04,
                {(k >= 1 && k <= 11) ? 8'(k) : dspa_pkg::ERR_OTHER, 16'h0000, 8'hff});
        end
        rd(dspa_pkg::ADDR_PARAM_STAT, 32'h0000_0011);
        complete_run();
    end
endmodule
